// file: hdl/ptc_clock_control.v
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "ptc_regs.vh"

// Overview of operation
// - Step command adjusts clock by nanosecond value
// - Step direction one adds, zero subtracts
// - Snapshot command copies clock into time registers
// - Load command overwrites clock from time registers
// - Continuous adjust trims increment by rate
// - Enable resets to one; clear freezes clock
// - Clock reset command returns clock to zero
// - Nanoseconds 30 bits, seconds 32 bits split
// - Advance per 40ns period, 8ns phase slots
// - Writing seconds or nanoseconds zeroes phase
// - Zero rate disables frequency adjustment
module ptc_clock_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire ref_tick
);

  // Stored control fields
  reg step_dir_reg;
  reg cont_adj_reg;
  reg enable_reg;
  // Pending self-clearing commands
  reg step_pend_reg;
  reg snap_pend_reg;
  reg load_pend_reg;
  reg clr_pend_reg;
  // Time and rate registers
  reg [15:0] nsl_reg;
  reg [13:0] nsh_reg;
  reg [15:0] sl_reg;
  reg [15:0] sh_reg;
  reg [2:0] phase_reg;
  reg [15:0] rate_l_reg;
  reg [15:0] rate_h_reg;
  // Read mux result
  reg [15:0] rd_val;
  reg rd_hit;

  // Live clock value from the core
  wire [31:0] core_sec;
  wire [29:0] core_ns;
  wire [2:0] core_phase;

  // Bus qualifiers
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire [13:0] idx = paddr[15:2];

  // Write qualifiers per register
  wire wr_ctl = wr && (idx == `PTC_IDX_CTL);
  wire wr_nsl = wr && (idx == `PTC_IDX_NSL);
  wire wr_nsh = wr && (idx == `PTC_IDX_NSH);
  wire wr_sl = wr && (idx == `PTC_IDX_SL);
  wire wr_sh = wr && (idx == `PTC_IDX_SH);
  wire wr_phase = wr && (idx == `PTC_IDX_PHASE);
  wire wr_rate_l = wr && (idx == `PTC_IDX_RATE_L);
  wire wr_rate_h = wr && (idx == `PTC_IDX_RATE_H);

  // Byte-lane merge of a 16-bit register with the write data
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  wire [15:0] ctl_w = merge16(16'h0000, pwdata[15:0], pstrb[1:0]);
  wire ctl_lane = wr_ctl && pstrb[0];
  // High nanosecond word after the lane merge; its two top bits are dropped
  wire [15:0] nsh_w = merge16({2'b00, nsh_reg}, pwdata[15:0], pstrb[1:0]);

  // Zero wait states
  assign pready = 1'b1;

  // Control register readback; command bits show pending state
  wire [15:0] ctl_rd = {9'h000, step_pend_reg, step_dir_reg, snap_pend_reg,
                        load_pend_reg, cont_adj_reg, enable_reg, clr_pend_reg};

  // Read decode
  always @* begin
    rd_val = `PTC_ZERO16;
    rd_hit = 1'b1;
    case (idx)
      `PTC_IDX_CTL: rd_val = ctl_rd;
      `PTC_IDX_NSL: rd_val = nsl_reg;
      `PTC_IDX_NSH: rd_val = {2'b00, nsh_reg};
      `PTC_IDX_SL: rd_val = sl_reg;
      `PTC_IDX_SH: rd_val = sh_reg;
      `PTC_IDX_PHASE: rd_val = {13'h0000, phase_reg};
      `PTC_IDX_RATE_L: rd_val = rate_l_reg;
      `PTC_IDX_RATE_H: rd_val = rate_h_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data and error registered in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {16'h0000, rd_val};
      pslverr <= !rd_hit;
    end
  end

  // Control fields and self-clearing commands; a new set beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_dir_reg <= 1'b0;
      cont_adj_reg <= 1'b0;
      enable_reg <= `PTC_CTL_RESET;
      step_pend_reg <= 1'b0;
      snap_pend_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
    end else begin
      if (ctl_lane) begin
        step_dir_reg <= ctl_w[`PTC_BIT_STEP_DIR];
        cont_adj_reg <= ctl_w[`PTC_BIT_CONT_ADJ];
        enable_reg <= ctl_w[`PTC_BIT_ENABLE];
      end
      step_pend_reg <= ctl_lane && ctl_w[`PTC_BIT_STEP];
      snap_pend_reg <= ctl_lane && ctl_w[`PTC_BIT_SNAP];
      load_pend_reg <= ctl_lane && ctl_w[`PTC_BIT_LOAD];
      clr_pend_reg <= ctl_lane && ctl_w[`PTC_BIT_CLK_RST];
    end
  end

  // Time registers: software writes, snapshot overwrites
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nsl_reg <= `PTC_ZERO16;
      nsh_reg <= 14'h0000;
      sl_reg <= `PTC_ZERO16;
      sh_reg <= `PTC_ZERO16;
      phase_reg <= 3'h0;
    end else if (snap_pend_reg) begin
      // Snapshot of the live clock
      nsl_reg <= core_ns[15:0];
      nsh_reg <= core_ns[29:16];
      sl_reg <= core_sec[15:0];
      sh_reg <= core_sec[31:16];
      phase_reg <= core_phase;
    end else begin
      if (wr_nsl) begin
        nsl_reg <= merge16(nsl_reg, pwdata[15:0], pstrb[1:0]);
      end
      if (wr_nsh) begin
        nsh_reg <= nsh_w[13:0];
      end
      if (wr_sl) begin
        sl_reg <= merge16(sl_reg, pwdata[15:0], pstrb[1:0]);
      end
      if (wr_sh) begin
        sh_reg <= merge16(sh_reg, pwdata[15:0], pstrb[1:0]);
      end
      if (wr_nsl || wr_nsh || wr_sl || wr_sh) begin
        phase_reg <= 3'h0;
      end else if (wr_phase && pstrb[0]) begin
        phase_reg <= pwdata[2:0];
      end
    end
  end

  // Rate registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_l_reg <= `PTC_ZERO16;
      rate_h_reg <= `PTC_ZERO16;
    end else begin
      if (wr_rate_l) begin
        rate_l_reg <= merge16(rate_l_reg, pwdata[15:0], pstrb[1:0]);
      end
      if (wr_rate_h) begin
        rate_h_reg <= merge16(rate_h_reg, pwdata[15:0], pstrb[1:0]) & 16'hBFFF;
      end
    end
  end

  // Load and step rely on software having filled the time registers first
  ptc_time_core i_ptc_time_core (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clr_pend_reg),
    .load(load_pend_reg),
    .load_sec({sh_reg, sl_reg}),
    .load_ns({nsh_reg, nsl_reg}),
    .load_phase(phase_reg),
    .step(step_pend_reg),
    .step_add(step_dir_reg),
    .step_ns({nsh_reg, nsl_reg}),
    .run(enable_reg),
    .tick(ref_tick),
    .adj_en(cont_adj_reg),
    .rate({2'b00, rate_h_reg[`PTC_RATE_H_MSB:0], rate_l_reg}),
    .rate_dec(rate_h_reg[`PTC_BIT_RATE_DIR]),
    .sec(core_sec),
    .ns(core_ns),
    .phase(core_phase)
  );

endmodule // ptc_clock_control

// file: hdl/ptc_regs.vh
`ifndef PTC_REGS_VH
`define PTC_REGS_VH

// Register indices; byte address is four times the index
`define PTC_IDX_CTL 14'h0600
`define PTC_IDX_NSL 14'h0604
`define PTC_IDX_NSH 14'h0606
`define PTC_IDX_SL 14'h0608
`define PTC_IDX_SH 14'h060A
`define PTC_IDX_PHASE 14'h060C
`define PTC_IDX_RATE_L 14'h0610
`define PTC_IDX_RATE_H 14'h0612

// Control register field positions
`define PTC_BIT_STEP 6
`define PTC_BIT_STEP_DIR 5
`define PTC_BIT_SNAP 4
`define PTC_BIT_LOAD 3
`define PTC_BIT_CONT_ADJ 2
`define PTC_BIT_ENABLE 1
`define PTC_BIT_CLK_RST 0

// Rate high word layout
`define PTC_BIT_RATE_DIR 15
`define PTC_RATE_H_MSB 13

// Reset values
`define PTC_CTL_RESET 1'b1
`define PTC_ZERO16 16'h0000

// Time constants
`define PTC_REF_PERIOD_NS 31'h0000_0028
`define PTC_NS_PER_SEC 31'h3B9A_CA00
`define PTC_PHASE_MAX 3'h4

`endif

// file: hdl/ptc_time_core.v
`timescale 1ns/1ps
`include "ptc_regs.vh"

// Running time counter: seconds, nanoseconds, sub-phase and rate accumulator
module ptc_time_core (
  input wire pclk,
  input wire presetn,
  input wire clr,
  input wire load,
  input wire [31:0] load_sec,
  input wire [29:0] load_ns,
  input wire [2:0] load_phase,
  input wire step,
  input wire step_add,
  input wire [29:0] step_ns,
  input wire run,
  input wire tick,
  input wire adj_en,
  input wire [31:0] rate,
  input wire rate_dec,
  output wire [31:0] sec,
  output wire [29:0] ns,
  output wire [2:0] phase
);

  reg [31:0] sec_reg;
  reg [29:0] ns_reg;
  reg [2:0] phase_reg;
  reg [31:0] frac_reg;
  reg [31:0] sec_next;
  reg [29:0] ns_next;
  reg [2:0] phase_next;
  reg [31:0] frac_next;
  reg [30:0] incr;
  reg [30:0] sum;

  // Fractional accumulator sum and difference with carry or borrow
  wire [32:0] frac_sum = {1'b0, frac_reg} + {1'b0, rate};
  wire [32:0] frac_dif = {1'b0, frac_reg} - {1'b0, rate};
  // Zero rate disables adjustment entirely
  wire adj_on = adj_en && (rate != 32'h0000_0000);

  // Next state: reset, then load, then step, then normal advance
  always @* begin
    sec_next = sec_reg;
    ns_next = ns_reg;
    phase_next = phase_reg;
    frac_next = frac_reg;
    incr = `PTC_REF_PERIOD_NS;
    sum = 31'h0000_0000;
    if (clr) begin
      // Back to the initial state
      sec_next = 32'h0000_0000;
      ns_next = 30'h0000_0000;
      phase_next = 3'h0;
      frac_next = 32'h0000_0000;
    end else if (load) begin
      // Overwrite with software time
      sec_next = load_sec;
      ns_next = load_ns;
      phase_next = (load_phase > `PTC_PHASE_MAX) ? `PTC_PHASE_MAX : load_phase;
    end else if (step) begin
      if (step_add) begin
        // Forward step with second carry
        sum = {1'b0, ns_reg} + {1'b0, step_ns};
        if (sum >= `PTC_NS_PER_SEC) begin
          sum = sum - `PTC_NS_PER_SEC;
          sec_next = sec_reg + 32'h0000_0001;
        end
      end else begin
        // Backward step with second borrow
        if (ns_reg >= step_ns) begin
          sum = {1'b0, ns_reg} - {1'b0, step_ns};
        end else begin
          sum = {1'b0, ns_reg} + `PTC_NS_PER_SEC - {1'b0, step_ns};
          sec_next = sec_reg - 32'h0000_0001;
        end
      end
      ns_next = sum[29:0];
    end else if (run && tick) begin
      // One reference period, trimmed by the rate accumulator
      if (adj_on) begin
        if (rate_dec) begin
          frac_next = frac_dif[31:0];
          incr = `PTC_REF_PERIOD_NS - {30'h0000_0000, frac_dif[32]};
        end else begin
          frac_next = frac_sum[31:0];
          incr = `PTC_REF_PERIOD_NS + {30'h0000_0000, frac_sum[32]};
        end
      end
      sum = {1'b0, ns_reg} + incr;
      if (sum >= `PTC_NS_PER_SEC) begin
        sum = sum - `PTC_NS_PER_SEC;
        sec_next = sec_reg + 32'h0000_0001;
      end
      ns_next = sum[29:0];
    end
  end

  // Time state; a cleared enable freezes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_reg <= 32'h0000_0000;
      ns_reg <= 30'h0000_0000;
      phase_reg <= 3'h0;
      frac_reg <= 32'h0000_0000;
    end else begin
      sec_reg <= sec_next;
      ns_reg <= ns_next;
      phase_reg <= phase_next;
      frac_reg <= frac_next;
    end
  end

  assign sec = sec_reg;
  assign ns = ns_reg;
  assign phase = phase_reg;

endmodule // ptc_time_core

// file: tb/ptc_clock_control_checker.sv
`timescale 1ns/1ps
`include "ptc_regs.vh"

// Watches the register port of the clock control block
module ptc_clock_control_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ref_tick
);
  // Access phase, read access and decoded index
  wire acc = psel && penable;
  wire rda = acc && !pwrite;
  wire [13:0] idx = paddr[15:2];
  wire map = idx == `PTC_IDX_CTL || idx == `PTC_IDX_NSL || idx == `PTC_IDX_NSH
    || idx == `PTC_IDX_SL || idx == `PTC_IDX_SH || idx == `PTC_IDX_PHASE
    || idx == `PTC_IDX_RATE_L || idx == `PTC_IDX_RATE_H;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && !map |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && map |-> !pslverr)
    else $error("error on mapped access");
  a_unmapped_zero: assert property (rda && !map |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Control write that may set a command bit; it reads back one for a cycle
  wire wctl = acc && pwrite && idx == `PTC_IDX_CTL && pstrb[0];
  a_cmd_cleared: assert property (rda && idx == `PTC_IDX_CTL && !$past(wctl, 2) |->
    !prdata[6] && !prdata[4] && !prdata[3] && !prdata[0]) else $error("command bit still set");
  a_ctl_reserved: assert property (rda && idx == `PTC_IDX_CTL |-> prdata[31:7] == 25'h0)
    else $error("control reserved bits set");
  a_phase_width: assert property (rda && idx == `PTC_IDX_PHASE |-> prdata[31:3] == 29'h0)
    else $error("phase reserved bits set");
  a_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0000)
    else $error("upper read half set");
  a_resp_hold: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("response moved outside setup");
endmodule // ptc_clock_control_checker

bind ptc_clock_control ptc_clock_control_checker i_ptc_clock_control_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_tick(ref_tick));

// file: tb/test_ptp_clock_control.sv
`timescale 1ns/1ps
`include "ptc_regs.vh"

// Self-checking bench: APB driver, read monitor, time model
module test_ptp_clock_control;
  localparam logic [15:0] A_CTL = 16'h1800, A_NSL = 16'h1810, A_NSH = 16'h1818;
  localparam logic [15:0] A_SL = 16'h1820, A_SH = 16'h1828, A_PH = 16'h1830;
  localparam logic [15:0] A_RL = 16'h1840, A_RH = 16'h1848;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_tick = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  logic [32:0] exp_q[$]; // Expected {error, data} of pending reads
  longint unsigned t; // Model clock in nanoseconds
  logic [15:0] ctl; // Control value without command bits
  logic [2:0] ph; // Model sub-phase
  logic [29:0] v;

  ptc_clock_control i_ptc_clock_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_tick(ref_tick));

  always #50 pclk = ~pclk;

  // Compare one read result with the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      check_val($sformatf("read %h", paddr), {pslverr, prdata}, exp_q[0]);
      void'(exp_q.pop_front());
    end
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  // One APB transfer, held until pready
  task automatic xfer(input logic [15:0] a, input logic w, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= 4'b0011;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 16'h0000);
  endtask

  // Writes nanoseconds, optionally seconds too
  task automatic wtime(input longint unsigned x, input logic both);
    logic [31:0] s;
    logic [29:0] n;
    s = 32'(x / `PTC_NS_PER_SEC);
    n = 30'(x % `PTC_NS_PER_SEC);
    if (both) xfer(A_SL, 1'b1, s[15:0]);
    if (both) xfer(A_SH, 1'b1, s[31:16]);
    xfer(A_NSL, 1'b1, n[15:0]);
    xfer(A_NSH, 1'b1, {2'b00, n[29:16]});
  endtask

  // Snapshot the clock and read back all time registers
  task automatic snap;
    logic [31:0] s;
    logic [29:0] n;
    s = 32'(t / `PTC_NS_PER_SEC);
    n = 30'(t % `PTC_NS_PER_SEC);
    xfer(A_CTL, 1'b1, ctl | 16'h0010);
    rd(A_SL, {17'h0, s[15:0]});
    rd(A_SH, {17'h0, s[31:16]});
    rd(A_NSL, {17'h0, n[15:0]});
    rd(A_NSH, {19'h0, n[29:16]});
    rd(A_PH, {30'h0, ph});
  endtask

  // Reference pulses; the model advances only while enabled
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge pclk);
      ref_tick <= 1'b1;
      @(posedge pclk);
      ref_tick <= 1'b0;
    end
    if (ctl[1]) t += k * `PTC_REF_PERIOD_NS;
  endtask

  // Compares one seen value with its expected value
  task automatic check_val(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hc052));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 33'h0_0000_0002);
    rd(16'h1804, 33'h1_0000_0000);
    // Time and rate registers reset to zero; the gap at index 0x60E is unmapped
    for (int i = 0; i < 8; i++) rd(A_NSL + 16'(i * 8), (i == 5) ? 33'h1_0000_0000 : 33'h0);
    // Frozen load of a random time and phase
    ctl = 16'h0000;
    xfer(A_CTL, 1'b1, ctl);
    t = {32'h0, $urandom & 32'h7FFF_FFFF} * `PTC_NS_PER_SEC + $urandom % 32'h3B9A_0000;
    ph = 3'($urandom % 5);
    wtime(t, 1'b1);
    xfer(A_PH, 1'b1, {13'h0, ph});
    rd(A_PH, {30'h0, ph});
    xfer(A_CTL, 1'b1, 16'h0008);
    xfer(A_NSL, 1'b1, 16'hFFFF);
    rd(A_PH, 33'h0);
    rd(A_CTL, 33'h0);
    ticks(3);
    snap();
    ctl = 16'h0002;
    xfer(A_CTL, 1'b1, ctl);
    ticks(5);
    snap();
    // Seconds carry on the nanosecond wrap
    t = (t / `PTC_NS_PER_SEC) * `PTC_NS_PER_SEC + 64'h0000_0000_3B9A_C9EC;
    ph = 3'h0;
    wtime(t, 1'b1);
    xfer(A_CTL, 1'b1, ctl | 16'h0008);
    ticks(1);
    snap();
    // Subtract with borrow, then add
    for (int d = 0; d < 2; d++) begin
      v = 30'($urandom % `PTC_NS_PER_SEC);
      wtime(64'(v), 1'b0);
      xfer(A_CTL, 1'b1, ctl | 16'h0040 | 16'(d << 5));
      t = d ? t + v : t - v;
      snap();
    end
    // Continuous adjustment up and down from a cleared clock
    ctl = 16'h0006;
    for (int d = 0; d < 2; d++) begin
      xfer(A_RL, 1'b1, 16'hFFFF);
      xfer(A_RH, 1'b1, {d[0], 15'h3FFF});
      xfer(A_CTL, 1'b1, ctl | 16'h0001);
      t = 0;
      ticks(8);
      // Eight trims of just under a quarter nanosecond: whole part moves up 1 or down 2
      t = d ? t - 2 : t + 1;
      snap();
    end
    xfer(A_CTL, 1'b1, ctl | 16'h0001);
    t = 0;
    snap();
    xfer(A_RL, 1'b1, 16'h0000);
    xfer(A_RH, 1'b1, 16'h0000);
    ticks(8);
    snap();
    close_out();
  end
endmodule // test_ptp_clock_control
